// ---- logic/oqt_timer.sv ----
`timescale 1ns/10ps
module oqt_timer #(
  parameter int unsigned CHANNEL = oqt_pkg::CHAN_SECOND
) (
  input wire logic clk,
  input wire logic resetn,
  input wire oqt_pkg::oqt_cfg_t cfg,
  input wire logic event_input_pin,
  input wire logic auxiliary_io_pin_in,
  output logic auxiliary_io_pin_out,
  output logic auxiliary_io_pin_oe_n,
  input wire logic subclock_pin,
  input wire logic timer_ovf_in,
  input wire logic oneshot_start,
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  output logic [15:0] rd_data,
  output logic running,
  output logic irq
);
  oqt_pkg::oqt_state_t q, d;

  logic ev_chg, aux_chg, sub_rise, ev_new, aux_new;
  logic x4_eff, tick, up, dn, trig, counting;

  // Prescaler taps fire when the low bits of the free counter are all ones; the sub tap fires when the sub edge counter wraps
  function automatic logic src_tick(input oqt_pkg::oqt_src_t s, input logic [4:0] p,
                                    input logic sub_wrap);
    unique case (s)
      oqt_pkg::OQT_SRC_DIV1: src_tick = 1'b1;
      oqt_pkg::OQT_SRC_DIV2: src_tick = p[0];
      oqt_pkg::OQT_SRC_DIV8: src_tick = (p[2:0] == oqt_pkg::PRE_DIV8_MASK);
      oqt_pkg::OQT_SRC_DIV32: src_tick = (p == oqt_pkg::PRE_ALL);
      oqt_pkg::OQT_SRC_SUB32: src_tick = sub_wrap;
      default: src_tick = 1'b0;
    endcase
  endfunction

  always_comb begin
    d = q;
    d.sync_ev = {q.sync_ev[1:0], event_input_pin};
    d.sync_aux = {q.sync_aux[1:0], auxiliary_io_pin_in};
    d.sync_sub = {q.sync_sub[1:0], subclock_pin};
    // Filtered levels move only when stages two and three agree
    ev_chg = (q.sync_ev[1] == q.sync_ev[2]) && (q.sync_ev[2] != q.ev);
    aux_chg = (q.sync_aux[1] == q.sync_aux[2]) && (q.sync_aux[2] != q.aux);
    sub_rise = (q.sync_sub[1] == q.sync_sub[2]) && q.sync_sub[2] && !q.sub;
    ev_new = ev_chg ? q.sync_ev[2] : q.ev;
    aux_new = aux_chg ? q.sync_aux[2] : q.aux;
    d.ev = ev_new;
    d.aux = aux_new;
    d.sub = (q.sync_sub[1] == q.sync_sub[2]) ? q.sync_sub[2] : q.sub;
    d.pre = q.pre + 5'h01;
    d.subdiv = sub_rise ? q.subdiv + 5'h01 : q.subdiv;
    d.irq = 1'b0;

    if (CHANNEL == oqt_pkg::CHAN_SECOND) begin
      x4_eff = cfg.x4_sel;
    end else begin
      x4_eff = (CHANNEL == oqt_pkg::CHAN_THIRD);
    end

    tick = src_tick(cfg.src_sel, q.pre, sub_rise && (q.subdiv == oqt_pkg::PRE_ALL));

    up = 1'b0;
    dn = 1'b0;
    if (x4_eff) begin
      // Simultaneous change of both phases carries no direction, so skip it
      if (ev_chg != aux_chg) begin
        up = (ev_new == q.aux);
        dn = (ev_new != q.aux);
      end
    end else if (ev_chg && q.aux) begin
      up = ev_new;
      dn = !ev_new;
    end

    trig = oneshot_start
      || (cfg.pin_trig_en && ev_chg && ev_new)
      || (cfg.ovf_trig_en && timer_ovf_in);
    counting = (cfg.mode == oqt_pkg::OQT_MODE_ONESHOT) ? (q.fsm == oqt_pkg::OQT_RUN)
                                                       : cfg.count_start;

    if (cfg.mode == oqt_pkg::OQT_MODE_QUAD) begin
      d.fsm = oqt_pkg::OQT_IDLE;
      d.pulse = 1'b0;
      if (cfg.count_start && up) begin
        if (q.cnt == oqt_pkg::CNT_MAX) begin
          d.irq = 1'b1;
          d.cnt = cfg.free_run ? oqt_pkg::CNT_ZERO : q.rld;
        end else begin
          d.cnt = q.cnt + 16'h0001;
        end
      end else if (cfg.count_start && dn) begin
        if (q.cnt == oqt_pkg::CNT_ZERO) begin
          d.irq = 1'b1;
          d.cnt = cfg.free_run ? oqt_pkg::CNT_MAX : q.rld;
        end else begin
          d.cnt = q.cnt - 16'h0001;
        end
      end
      d.rd = q.cnt;
    end else begin
      d.rd = oqt_pkg::RD_UNDEF;
      unique case (q.fsm)
        oqt_pkg::OQT_IDLE: begin
          if (cfg.count_start && trig) begin
            d.fsm = oqt_pkg::OQT_RUN;
            d.cnt = q.rld;
          end
        end
        oqt_pkg::OQT_RUN: begin
          if (!cfg.count_start) begin
            d.fsm = oqt_pkg::OQT_IDLE;
          end else if (trig) begin
            d.cnt = q.rld;
          end else if (tick) begin
            // Zero or one left means this tick reaches zero
            if (q.cnt <= 16'h0001) begin
              d.irq = 1'b1;
              d.cnt = q.rld;
              d.fsm = oqt_pkg::OQT_IDLE;
            end else begin
              d.cnt = q.cnt - 16'h0001;
            end
          end
        end
      endcase
      d.pulse = (d.fsm == oqt_pkg::OQT_RUN);
    end

    // Host write always loads the reload value; the counter takes it only while not counting
    if (wr_en) begin
      d.rld = wr_data;
      if (!counting) begin
        d.cnt = wr_data;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '{sync_ev: 3'h0, sync_aux: 3'h0, sync_sub: 3'h0, ev: 1'b0, aux: 1'b0,
             sub: 1'b0, pre: oqt_pkg::PRE_RST, subdiv: oqt_pkg::PRE_RST,
             cnt: oqt_pkg::CNT_RST, rld: oqt_pkg::CNT_RST, fsm: oqt_pkg::OQT_IDLE,
             irq: 1'b0, pulse: 1'b0, rd: oqt_pkg::CNT_RST};
    end else begin
      q <= d;
    end
  end

  assign rd_data = q.rd;
  assign irq = q.irq;
  assign running = (cfg.mode == oqt_pkg::OQT_MODE_ONESHOT) ? (q.fsm == oqt_pkg::OQT_RUN)
                                                           : cfg.count_start;
  // Auxiliary pin stays an input unless it carries the one-shot pulse
  assign auxiliary_io_pin_out = q.pulse;
  assign auxiliary_io_pin_oe_n = !(cfg.pulse_out_en && cfg.mode == oqt_pkg::OQT_MODE_ONESHOT);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_norm_up;
    !x4_eff && cfg.mode == oqt_pkg::OQT_MODE_QUAD && cfg.count_start && ev_chg && ev_new
      && q.aux && q.cnt != oqt_pkg::CNT_MAX && !wr_en |=> q.cnt == $past(q.cnt) + 16'h0001;
  endproperty
  a_norm_up: assert property (p_norm_up) else $error("normal up count missed");

  property p_x4_up;
    x4_eff && cfg.mode == oqt_pkg::OQT_MODE_QUAD && cfg.count_start && ev_chg && !aux_chg
      && ev_new == q.aux && q.cnt != oqt_pkg::CNT_MAX && !wr_en
      |=> q.cnt == $past(q.cnt) + 16'h0001;
  endproperty
  a_x4_up: assert property (p_x4_up) else $error("by-4 up count missed");

  property p_x4_dn;
    x4_eff && cfg.mode == oqt_pkg::OQT_MODE_QUAD && cfg.count_start && aux_chg && !ev_chg
      && q.ev == aux_new && q.cnt != oqt_pkg::CNT_ZERO && !wr_en
      |=> q.cnt == $past(q.cnt) - 16'h0001;
  endproperty
  a_x4_dn: assert property (p_x4_dn) else $error("by-4 down count missed");

  property p_free;
    cfg.mode == oqt_pkg::OQT_MODE_QUAD && cfg.free_run && cfg.count_start && up
      && q.cnt == oqt_pkg::CNT_MAX && !wr_en |=> q.cnt == oqt_pkg::CNT_ZERO && irq;
  endproperty
  a_free: assert property (p_free) else $error("free-run overflow reloaded");

  property p_zero_halt;
    q.fsm == oqt_pkg::OQT_RUN && cfg.mode == oqt_pkg::OQT_MODE_ONESHOT && cfg.count_start
      && !trig && tick && q.cnt == 16'h0001 && !wr_en
      |=> irq && q.fsm == oqt_pkg::OQT_IDLE && q.cnt == q.rld;
  endproperty
  a_zero_halt: assert property (p_zero_halt) else $error("one-shot end wrong");

  property p_retrig;
    q.fsm == oqt_pkg::OQT_RUN && cfg.mode == oqt_pkg::OQT_MODE_ONESHOT && cfg.count_start
      && trig && !wr_en |=> q.cnt == $past(q.rld) && q.fsm == oqt_pkg::OQT_RUN;
  endproperty
  a_retrig: assert property (p_retrig) else $error("retrigger not reloaded");

  property p_stop;
    q.fsm == oqt_pkg::OQT_RUN && cfg.mode == oqt_pkg::OQT_MODE_ONESHOT && !cfg.count_start
      |=> q.fsm == oqt_pkg::OQT_IDLE && !irq;
  endproperty
  a_stop: assert property (p_stop) else $error("start flag clear did not stop");

  property p_irq_cause;
    irq |-> $past(q.cnt) == 16'h0001 || $past(q.cnt) == oqt_pkg::CNT_ZERO
      || $past(q.cnt) == oqt_pkg::CNT_MAX;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without terminal count");

  property p_wr_stopped;
    wr_en && !counting |=> q.cnt == $past(wr_data) && q.rld == $past(wr_data);
  endproperty
  a_wr_stopped: assert property (p_wr_stopped) else $error("stopped write lost");

  property p_wr_run;
    wr_en && counting && cfg.mode == oqt_pkg::OQT_MODE_ONESHOT && !trig && !tick
      |=> q.rld == $past(wr_data) && q.cnt == $past(q.cnt);
  endproperty
  a_wr_run: assert property (p_wr_run) else $error("running write hit counter");

  property p_start_delay;
    cfg.mode == oqt_pkg::OQT_MODE_ONESHOT && q.fsm == oqt_pkg::OQT_IDLE && cfg.count_start
      && oneshot_start ##1 cfg.count_start && cfg.mode == oqt_pkg::OQT_MODE_ONESHOT
      |-> running && auxiliary_io_pin_out;
  endproperty
  a_start_delay: assert property (p_start_delay) else $error("one-shot did not start");

  c_oneshot_done: cover property (q.fsm == oqt_pkg::OQT_RUN ##[1:200] irq);
  c_retrig: cover property (q.fsm == oqt_pkg::OQT_RUN && trig);
  c_x4_down: cover property (x4_eff && dn && cfg.count_start);
  c_underflow: cover property (cfg.mode == oqt_pkg::OQT_MODE_QUAD && irq);
endmodule

// ---- logic/oqt_pkg.sv ----
package oqt_pkg;
  localparam int unsigned CNT_W = 16;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] RD_UNDEF = 16'h0000;
  localparam logic [4:0] PRE_ALL = 5'h1f;
  localparam logic [2:0] PRE_DIV8_MASK = 3'h7;
  localparam logic [4:0] PRE_RST = 5'h00;
  // Channel positions among the quadrature-capable channels
  localparam int unsigned CHAN_FIRST = 0;
  localparam int unsigned CHAN_SECOND = 1;
  localparam int unsigned CHAN_THIRD = 2;

  typedef enum logic [2:0] {
    OQT_SRC_DIV1 = 3'b000,
    OQT_SRC_DIV2 = 3'b001,
    OQT_SRC_DIV8 = 3'b010,
    OQT_SRC_DIV32 = 3'b011,
    OQT_SRC_SUB32 = 3'b100
  } oqt_src_t;

  typedef enum logic {
    OQT_MODE_QUAD = 1'b0,
    OQT_MODE_ONESHOT = 1'b1
  } oqt_mode_t;

  typedef enum logic {
    OQT_IDLE = 1'b0,
    OQT_RUN = 1'b1
  } oqt_fsm_t;

  typedef struct packed {
    oqt_mode_t mode;
    logic count_start;
    logic x4_sel;
    logic free_run;
    oqt_src_t src_sel;
    logic pin_trig_en;
    logic ovf_trig_en;
    logic pulse_out_en;
  } oqt_cfg_t;

  typedef struct packed {
    logic [2:0] sync_ev;
    logic [2:0] sync_aux;
    logic [2:0] sync_sub;
    logic ev;
    logic aux;
    logic sub;
    logic [4:0] pre;
    logic [4:0] subdiv;
    logic [15:0] cnt;
    logic [15:0] rld;
    oqt_fsm_t fsm;
    logic irq;
    logic pulse;
    logic [15:0] rd;
  } oqt_state_t;
endpackage

// ---- dv/oqt_encoder_model.sv ----
`timescale 1ns/10ps
module oqt_encoder_model (
  input wire logic [1:0] pos,
  output logic phase_a,
  output logic phase_b,
  output logic sub_clk
);
  // Gray steps 00,01,11,10 count up: auxiliary phase leads
  assign phase_a = pos[1];
  assign phase_b = pos[1] ^ pos[0];
  // Free-running sub clock, phase unrelated to clk
  initial begin
    sub_clk = 1'b0;
    #3.3;
    forever #35 sub_clk = ~sub_clk;
  end
endmodule

// ---- dv/oqt_timer_test.sv ----
`timescale 1ns/10ps
module oqt_timer_test;
  logic clk, resetn, wr_en, timer_ovf_in, oneshot_start;
  logic [15:0] wr_data, rd_data;
  logic aux_out, oe_n, running, irq, ev, aux, sub;
  logic [1:0] pos;
  oqt_pkg::oqt_cfg_t cfg;
  int errors, check_count, irq_cnt, m_irq, m_cnt, m_rld, cyc;
  int seed = 8196;
  // Source period in clk cycles; sub entry is 32 ticks of a 7-cycle sub clock
  int kk[5] = '{1, 2, 8, 32, 224};

  oqt_timer #(.CHANNEL(oqt_pkg::CHAN_SECOND)) i_oqt_timer (.clk(clk), .resetn(resetn),
    .cfg(cfg), .event_input_pin(ev), .auxiliary_io_pin_in(aux),
    .auxiliary_io_pin_out(aux_out), .auxiliary_io_pin_oe_n(oe_n), .subclock_pin(sub),
    .timer_ovf_in(timer_ovf_in), .oneshot_start(oneshot_start), .wr_en(wr_en),
    .wr_data(wr_data), .rd_data(rd_data), .running(running), .irq(irq));
  oqt_encoder_model i_oqt_encoder_model (.pos(pos), .phase_a(ev), .phase_b(aux),
    .sub_clk(sub));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (irq === 1'b1) irq_cnt++;
    cyc++;
    if (cyc == 20000) begin
      errors++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bump(input int up);
    if (up != 0) begin
      if (m_cnt == 65535) begin
        m_cnt = cfg.free_run ? 0 : m_rld;
        m_irq++;
      end else m_cnt++;
    end else if (m_cnt == 0) begin
      m_cnt = cfg.free_run ? 65535 : m_rld;
      m_irq++;
    end else m_cnt--;
  endtask

  task automatic step(input int up);
    logic [1:0] old;
    old = pos;
    pos = up != 0 ? pos + 2'h1 : pos - 2'h1;
    if (cfg.count_start) begin
      if (cfg.x4_sel) bump(up);
      else if (old == 2'h1 && pos == 2'h2) bump(1);
      else if (old == 2'h2 && pos == 2'h1) bump(0);
    end
    repeat (6) @(negedge clk);
    chk(rd_data, 16'(m_cnt));
  endtask

  task automatic wr(input logic [15:0] v, input logic busy);
    wr_en = 1'b1;
    wr_data = v;
    @(negedge clk);
    wr_en = 1'b0;
    m_rld = v;
    if (!busy) m_cnt = v;
  endtask

  // Trigger 0 flag, 1 overflow, 2 pin; pulse length counted in clk cycles
  task automatic shot(input int trig, input int lo, input int hi, input int at);
    int len, ir;
    ir = irq_cnt;
    len = 0;
    if (trig == 0) oneshot_start = 1'b1;
    else if (trig == 1) timer_ovf_in = 1'b1;
    else pos = 2'h2;
    @(negedge clk);
    timer_ovf_in = 1'b0;
    for (int i = 0; i < 9000 && (len == 0 || running === 1'b1); i++) begin
      oneshot_start = i == at;
      if (aux_out === 1'b1) len++;
      @(negedge clk);
    end
    // Irq counter only sees the pulse at the next rising edge
    @(negedge clk);
    chk(16'(len >= lo && len <= hi), 16'h0001);
    chk(16'(irq_cnt - ir), 16'h0001);
    chk(rd_data, oqt_pkg::RD_UNDEF);
    chk({15'h0000, oe_n}, 16'h0000);
    pos = 2'h1;
    repeat (4) @(negedge clk);
  endtask

  initial begin
    cfg = '0;
    pos = 2'h0;
    resetn = 1'b0;
    wr_en = 1'b0;
    wr_data = 16'h0000;
    timer_ovf_in = 1'b0;
    oneshot_start = 1'b0;
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    chk(rd_data, oqt_pkg::CNT_RST);
    wr(16'h0005, 1'b0);
    cfg.count_start = 1'b1;
    repeat (24) step($random(seed) & 1);
    wr(16'($random(seed)), 1'b1);
    cfg.x4_sel = 1'b1;
    repeat (40) step($random(seed) & 1);
    for (int f = 0; f < 4; f++) begin
      cfg.free_run = f[1];
      cfg.count_start = 1'b0;
      wr(f[0] ? 16'h0001 : 16'hfffe, 1'b0);
      cfg.count_start = 1'b1;
      repeat (3) step(f[0] ? 0 : 1);
    end
    chk(16'(irq_cnt), 16'(m_irq));
    chk({15'h0000, oe_n}, 16'h0001);
    cfg = '0;
    cfg.mode = oqt_pkg::OQT_MODE_ONESHOT;
    cfg.count_start = 1'b1;
    cfg.pulse_out_en = 1'b1;
    cfg.pin_trig_en = 1'b1;
    cfg.ovf_trig_en = 1'b1;
    pos = 2'h1;
    repeat (4) @(negedge clk);
    wr(16'h0003, 1'b0);
    // Prescaler phase is free, so a pulse may lose up to one source period
    for (int s = 0; s < 5; s++) begin
      cfg.src_sel = oqt_pkg::oqt_src_t'(s);
      shot(0, 2 * kk[s] + 1 - (s / 4) * 8, 3 * kk[s] + (s / 4) * 8, -1);
    end
    cfg.src_sel = oqt_pkg::OQT_SRC_DIV1;
    shot(1, 3, 3, -1);
    shot(2, 3, 3, -1);
    wr(16'h0014, 1'b0);
    shot(0, 29, 31, 10);
    // Slow source leaves idle cycles so a running write can be seen alone
    cfg.src_sel = oqt_pkg::OQT_SRC_DIV32;
    oneshot_start = 1'b1;
    @(negedge clk);
    oneshot_start = 1'b0;
    wr(16'h0007, 1'b1);
    repeat (4) @(negedge clk);
    cfg.count_start = 1'b0;
    m_irq = irq_cnt;
    repeat (30) @(negedge clk);
    chk({15'h0000, running}, 16'h0000);
    chk(16'(irq_cnt - m_irq), 16'h0000);
    cfg.count_start = 1'b1;
    cfg.src_sel = oqt_pkg::OQT_SRC_DIV1;
    shot(0, 7, 7, -1);
    end_of_test();
  end
endmodule
